// *** rtl/vpsa_alu.sv ***
// vector negate, pack and search datapath slice with its accumulators
`timescale 1ns/100ps
module vpsa_alu
  import vpsa_pkg::*;
#(
  parameter int ACC_W = VPSA_ACC_W,
  parameter int PTR_W = VPSA_PTR_W
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire vpsa_req_t req,
  input wire logic [PTR_W-1:0] array_pointer_reg,
  output logic result_valid,
  output logic [31:0] result_word,
  output logic capture_valid,
  output logic [PTR_W-1:0] upper_index_capture,
  output logic [PTR_W-1:0] lower_index_capture,
  output logic [ACC_W-1:0] accumulator_zero,
  output logic [ACC_W-1:0] accumulator_one,
  output vpsa_flags_t flags,
  output logic illegal_issue
);
  typedef struct packed {
    logic result_valid;
    logic [31:0] result_word;
    logic capture_valid;
    logic [PTR_W-1:0] upper_index_capture;
    logic [PTR_W-1:0] lower_index_capture;
    logic [ACC_W-1:0] acc_zero;
    logic [ACC_W-1:0] acc_one;
    vpsa_flags_t flags;
    logic illegal_issue;
  } vpsa_state_t;

  vpsa_state_t state_r;
  vpsa_state_t state_nxt;

  logic take_hi;
  logic take_lo;
  logic [ACC_W-1:0] acc_one_cand;
  logic [ACC_W-1:0] acc_zero_cand;

  // two identical lanes; neither sees the other's outcome
  vpsa_half_search #(.ACC_W(ACC_W)) u_lane_hi (
    .candidate(req.src_a[31:16]),
    .acc_in(state_r.acc_one),
    .mode(req.mode),
    .take(take_hi),
    .acc_out(acc_one_cand)
  );

  vpsa_half_search #(.ACC_W(ACC_W)) u_lane_lo (
    .candidate(req.src_a[15:0]),
    .acc_in(state_r.acc_zero),
    .mode(req.mode),
    .take(take_lo),
    .acc_out(acc_zero_cand)
  );

  logic [16:0] neg_hi_full;
  logic [16:0] neg_lo_full;
  logic [15:0] neg_hi;
  logic [15:0] neg_lo;
  logic sat_hi;
  logic sat_lo;
  logic mode_ok;
  logic comp_ok_search;
  logic comp_ok_other;
  logic legal;

  function automatic logic comp_permitted(input vpsa_comp_t c);
    comp_permitted = (c != VPSA_COMP_OTHER);
  endfunction

  always_comb begin
    // subtract from zero; only the most negative half overflows
    neg_hi_full = 17'h0_0000 - {req.src_a[31], req.src_a[31:16]};
    neg_lo_full = 17'h0_0000 - {req.src_a[15], req.src_a[15:0]};
    sat_hi = (req.src_a[31:16] == VPSA_HALF_MIN);
    sat_lo = (req.src_a[15:0] == VPSA_HALF_MIN);
    neg_hi = sat_hi ? VPSA_HALF_MAX : neg_hi_full[15:0];
    neg_lo = sat_lo ? VPSA_HALF_MAX : neg_lo_full[15:0];
    mode_ok = (req.mode != no_search_mode);
    // only a non-indexed pointer load and a nop may ride along
    comp_ok_search = (req.slot_a != VPSA_COMP_OTHER) && (req.slot_b != VPSA_COMP_OTHER)
      && !(req.slot_a == VPSA_COMP_PTR_LOAD && req.slot_b == VPSA_COMP_PTR_LOAD)
      && !req.slot_reg_index;
    comp_ok_other = comp_permitted(req.slot_a) && comp_permitted(req.slot_b);
    legal = 1'b0;
    if (req.valid && req.wide) begin
      case (req.op)
        VPSA_OP_NEG: legal = comp_ok_other;
        VPSA_OP_PACK: legal = comp_ok_other;
        VPSA_OP_SEARCH: legal = mode_ok && comp_ok_search;
        default: legal = 1'b0;
      endcase
    end

    state_nxt = state_r;
    state_nxt.result_valid = 1'b0;
    state_nxt.capture_valid = 1'b0;
    state_nxt.illegal_issue = req.valid && !legal;
    if (legal) begin
      case (req.op)
        VPSA_OP_NEG: begin
          state_nxt.result_valid = 1'b1;
          state_nxt.result_word = {neg_hi, neg_lo};
          state_nxt.flags.zero = (neg_hi == 16'h0000) || (neg_lo == 16'h0000);
          state_nxt.flags.negative = neg_hi[15] || neg_lo[15];
          state_nxt.flags.overflow = sat_hi || sat_lo;
          if (sat_hi || sat_lo) begin
            state_nxt.flags.overflow_sticky = 1'b1;
          end
          // borrow-free only when subtracting zero, so carry marks a zero source half
          state_nxt.flags.carry = (req.src_a[31:16] == 16'h0000) || (req.src_a[15:0] == 16'h0000);
        end
        VPSA_OP_PACK: begin
          state_nxt.result_valid = 1'b1;
          state_nxt.result_word = {req.pack_half_0, req.pack_half_1};
        end
        VPSA_OP_SEARCH: begin
          state_nxt.capture_valid = 1'b1;
          state_nxt.acc_one = acc_one_cand;
          state_nxt.acc_zero = acc_zero_cand;
          if (take_hi) begin
            state_nxt.upper_index_capture = array_pointer_reg;
          end
          if (take_lo) begin
            state_nxt.lower_index_capture = array_pointer_reg;
          end
        end
        default: begin
          state_nxt.result_valid = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign result_valid = state_r.result_valid;
  assign result_word = state_r.result_word;
  assign capture_valid = state_r.capture_valid;
  assign upper_index_capture = state_r.upper_index_capture;
  assign lower_index_capture = state_r.lower_index_capture;
  assign accumulator_zero = state_r.acc_zero;
  assign accumulator_one = state_r.acc_one;
  assign flags = state_r.flags;
  assign illegal_issue = state_r.illegal_issue;

  // one-cycle copies so the checks can look back at what was taken
  logic legal_r;
  vpsa_req_t req_r;
  logic [PTR_W-1:0] ptr_r;
  logic [ACC_W-1:0] acc0_r;
  logic [ACC_W-1:0] acc1_r;
  vpsa_flags_t flags_r;
  always_ff @(posedge clk) begin
    legal_r <= legal && !sys_rst;
    req_r <= req;
    ptr_r <= array_pointer_reg;
    acc0_r <= state_r.acc_zero;
    acc1_r <= state_r.acc_one;
    flags_r <= state_r.flags;
  end

  property p_pack_place;
    @(posedge clk) disable iff (sys_rst)
    (legal && req.op == VPSA_OP_PACK) |=> result_valid && result_word == {$past(req.pack_half_0), $past(req.pack_half_1)};
  endproperty
  a_pack_place: assert property (p_pack_place) else $error("pack halves misplaced");

  property p_neg_halves;
    @(posedge clk) disable iff (sys_rst)
    (legal && req.op == VPSA_OP_NEG && req.src_a[31:16] != VPSA_HALF_MIN && req.src_a[15:0] != VPSA_HALF_MIN)
      |=> (result_word[31:16] + $past(req.src_a[31:16])) == 16'h0000 && (result_word[15:0] + $past(req.src_a[15:0])) == 16'h0000;
  endproperty
  a_neg_halves: assert property (p_neg_halves) else $error("negate half wrong");

  property p_no_mode;
    @(posedge clk) disable iff (sys_rst)
    (req.valid && req.op == VPSA_OP_SEARCH && req.mode == no_search_mode) |=> illegal_issue && !capture_valid;
  endproperty
  a_no_mode: assert property (p_no_mode) else $error("modeless search accepted");

  property p_bad_companion;
    @(posedge clk) disable iff (sys_rst)
    (req.valid && req.op == VPSA_OP_SEARCH && req.slot_reg_index) |=> illegal_issue;
  endproperty
  a_bad_companion: assert property (p_bad_companion) else $error("indexed companion accepted");

  property p_hi_capture;
    @(posedge clk) disable iff (sys_rst)
    (legal_r && req_r.op == VPSA_OP_SEARCH && req_r.mode == strict_greater_mode
      && $signed(req_r.src_a[31:16]) > $signed(acc1_r[15:0])) |-> upper_index_capture == ptr_r;
  endproperty
  a_hi_capture: assert property (p_hi_capture) else $error("upper capture missed");

  property p_lo_keep;
    @(posedge clk) disable iff (sys_rst)
    (legal_r && req_r.op == VPSA_OP_SEARCH && req_r.mode == strict_less_mode
      && $signed(req_r.src_a[15:0]) >= $signed(acc0_r[15:0])) |-> accumulator_zero == acc0_r;
  endproperty
  a_lo_keep: assert property (p_lo_keep) else $error("lower lane updated wrongly");

  property p_sign_ext;
    @(posedge clk) disable iff (sys_rst)
    (legal && req.op == VPSA_OP_SEARCH && take_lo) |=> accumulator_zero == {{(ACC_W-16){$past(req.src_a[15])}}, $past(req.src_a[15:0])};
  endproperty
  a_sign_ext: assert property (p_sign_ext) else $error("accumulator not sign-extended");

  property p_flags_hold;
    @(posedge clk) disable iff (sys_rst)
    (legal && req.op != VPSA_OP_NEG) |=> flags == $past(flags);
  endproperty
  a_flags_hold: assert property (p_flags_hold) else $error("flags changed");

  property p_neg_sat;
    @(posedge clk) disable iff (sys_rst)
    (legal && req.op == VPSA_OP_NEG && req.src_a[31:16] == VPSA_HALF_MIN)
      |=> result_word[31:16] == VPSA_HALF_MAX && flags.overflow && flags.overflow_sticky;
  endproperty
  a_neg_sat: assert property (p_neg_sat) else $error("negate did not saturate");

  // sticky overflow drops only through reset; the release edge still shows the old copy
  property p_sticky_keep;
    @(posedge clk) disable iff (sys_rst)
    (flags_r.overflow_sticky && !$past(sys_rst)) |-> flags.overflow_sticky;
  endproperty
  a_sticky_keep: assert property (p_sticky_keep) else $error("sticky overflow lost");

  property p_not_wide;
    @(posedge clk) disable iff (sys_rst)
    (req.valid && !req.wide) |=> illegal_issue && !result_valid && !capture_valid;
  endproperty
  a_not_wide: assert property (p_not_wide) else $error("narrow encoding accepted");

  property p_companion_ok;
    @(posedge clk) disable iff (sys_rst)
    (req.valid && req.wide && (req.op == VPSA_OP_NEG || req.op == VPSA_OP_PACK)
      && req.slot_a != VPSA_COMP_OTHER && req.slot_b != VPSA_COMP_OTHER) |=> result_valid && !illegal_issue;
  endproperty
  a_companion_ok: assert property (p_companion_ok) else $error("permitted companion refused");

  property p_two_loads;
    @(posedge clk) disable iff (sys_rst)
    (req.valid && req.op == VPSA_OP_SEARCH && req.slot_a == VPSA_COMP_PTR_LOAD
      && req.slot_b == VPSA_COMP_PTR_LOAD) |=> illegal_issue && !capture_valid;
  endproperty
  a_two_loads: assert property (p_two_loads) else $error("second pointer load accepted");

  property p_lo_capture;
    @(posedge clk) disable iff (sys_rst)
    (legal && req.op == VPSA_OP_SEARCH && take_lo) |=> lower_index_capture == $past(array_pointer_reg);
  endproperty
  a_lo_capture: assert property (p_lo_capture) else $error("lower capture missed");

  // an upper take with no lower take must leave the lower lane exactly as it was
  property p_lanes_apart;
    @(posedge clk) disable iff (sys_rst)
    (legal && req.op == VPSA_OP_SEARCH && take_hi && !take_lo)
      |=> accumulator_zero == $past(accumulator_zero) && lower_index_capture == $past(lower_index_capture);
  endproperty
  a_lanes_apart: assert property (p_lanes_apart) else $error("lower lane disturbed");

  property p_gt_tie;
    @(posedge clk) disable iff (sys_rst)
    (legal && req.op == VPSA_OP_SEARCH && req.mode == strict_greater_mode
      && req.src_a[31:16] == accumulator_one[15:0])
      |=> accumulator_one == $past(accumulator_one) && upper_index_capture == $past(upper_index_capture);
  endproperty
  a_gt_tie: assert property (p_gt_tie) else $error("greater mode took a tie");

  property p_ge_tie;
    @(posedge clk) disable iff (sys_rst)
    (legal && req.op == VPSA_OP_SEARCH && req.mode == greater_equal_mode
      && req.src_a[31:16] == accumulator_one[15:0]) |=> upper_index_capture == $past(array_pointer_reg);
  endproperty
  a_ge_tie: assert property (p_ge_tie) else $error("greater-equal mode missed a tie");

  property p_le_tie;
    @(posedge clk) disable iff (sys_rst)
    (legal && req.op == VPSA_OP_SEARCH && req.mode == less_equal_mode
      && req.src_a[15:0] == accumulator_zero[15:0]) |=> lower_index_capture == $past(array_pointer_reg);
  endproperty
  a_le_tie: assert property (p_le_tie) else $error("less-equal mode missed a tie");

  c_neg: cover property (@(posedge clk) disable iff (sys_rst) legal && req.op == VPSA_OP_NEG);
  c_pack: cover property (@(posedge clk) disable iff (sys_rst) legal && req.op == VPSA_OP_PACK);
  c_search_both: cover property (@(posedge clk) disable iff (sys_rst) legal && req.op == VPSA_OP_SEARCH && take_hi && take_lo);
  c_illegal: cover property (@(posedge clk) disable iff (sys_rst) illegal_issue);
endmodule // vpsa_alu

// *** rtl/vpsa_pkg.sv ***
// package of constants and carrier types for the vector pack/search alu slice
package vpsa_pkg;
  localparam int VPSA_HALF_W = 16;
  localparam int VPSA_WORD_W = 32;
  localparam int VPSA_ACC_W = 40;
  localparam int VPSA_PTR_W = 32;
  localparam int VPSA_HI_LSB = 16;
  localparam logic [15:0] VPSA_HALF_MAX = 16'h7fff;
  localparam logic [15:0] VPSA_HALF_MIN = 16'h8000;
  localparam logic [39:0] VPSA_ACC_RST = 40'h00_0000_0000;
  localparam logic [31:0] VPSA_WORD_RST = 32'h0000_0000;
  localparam int VPSA_LATENCY = 1;

  typedef enum logic [1:0] {
    VPSA_OP_NEG,
    VPSA_OP_PACK,
    VPSA_OP_SEARCH,
    VPSA_OP_NONE
  } vpsa_op_t;

  typedef enum logic [2:0] {
    strict_greater_mode,
    greater_equal_mode,
    strict_less_mode,
    less_equal_mode,
    no_search_mode
  } vpsa_mode_t;

  // companion slot content of a bundle as seen by the issue logic
  typedef enum logic [1:0] {
    VPSA_COMP_NONE,
    VPSA_COMP_PTR_LOAD,
    VPSA_COMP_NOP,
    VPSA_COMP_OTHER
  } vpsa_comp_t;

  typedef struct packed {
    logic valid;
    logic wide;
    vpsa_op_t op;
    vpsa_mode_t mode;
    vpsa_comp_t slot_a;
    vpsa_comp_t slot_b;
    logic slot_reg_index;
    logic [31:0] src_a;
    logic [15:0] pack_half_0;
    logic [15:0] pack_half_1;
  } vpsa_req_t;

  typedef struct packed {
    logic zero;
    logic negative;
    logic overflow;
    logic overflow_sticky;
    logic carry;
  } vpsa_flags_t;
endpackage

// *** rtl/vpsa_half_search.sv ***
// one half-word compare-and-select lane of the search
`timescale 1ns/100ps
module vpsa_half_search
  import vpsa_pkg::*;
#(
  parameter int ACC_W = VPSA_ACC_W
) (
  input wire logic [15:0] candidate,
  input wire logic [ACC_W-1:0] acc_in,
  input wire vpsa_mode_t mode,
  output logic take,
  output logic [ACC_W-1:0] acc_out
);
  logic signed [15:0] cand_s;
  logic signed [15:0] acc_s;

  always_comb begin
    cand_s = candidate;
    acc_s = acc_in[15:0];
    case (mode)
      strict_greater_mode: take = cand_s > acc_s;
      greater_equal_mode: take = cand_s >= acc_s;
      strict_less_mode: take = cand_s < acc_s;
      less_equal_mode: take = cand_s <= acc_s;
      default: take = 1'b0;
    endcase
    // sign extension fills every bit above the half
    acc_out = take ? {{(ACC_W-16){candidate[15]}}, candidate} : acc_in;
  end
endmodule // vpsa_half_search

// *** bench/vpsa_alu_bench.sv ***
// self-checking bench for the vector negate, pack and search slice
`timescale 1ns/100ps
module vpsa_alu_bench;
  import vpsa_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  vpsa_req_t req = '0;
  logic [31:0] array_pointer_reg = 32'h0000_0000;
  logic result_valid;
  logic capture_valid;
  logic illegal_issue;
  logic [31:0] result_word;
  logic [31:0] upper_index_capture;
  logic [31:0] lower_index_capture;
  logic [39:0] accumulator_zero;
  logic [39:0] accumulator_one;
  vpsa_flags_t flags;
  int n_mismatch = 0;
  int comparisons = 0;

  vpsa_alu dut (
    .clk(clk),
    .sys_rst(sys_rst),
    .req(req),
    .array_pointer_reg(array_pointer_reg),
    .result_valid(result_valid),
    .result_word(result_word),
    .capture_valid(capture_valid),
    .upper_index_capture(upper_index_capture),
    .lower_index_capture(lower_index_capture),
    .accumulator_zero(accumulator_zero),
    .accumulator_one(accumulator_one),
    .flags(flags),
    .illegal_issue(illegal_issue)
  );

  always #25 clk = ~clk;

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic end_of_test();
    $display("counts: comparisons=%0d n_mismatch=%0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  function automatic vpsa_req_t mk(vpsa_op_t op, vpsa_mode_t m, logic [31:0] s);
    mk = '0;
    mk.valid = 1'b1;
    mk.wide = 1'b1;
    mk.op = op;
    mk.mode = m;
    mk.src_a = s;
  endfunction

  // bench-side reference of one search lane's compare
  function automatic logic takes(vpsa_mode_t m, logic [15:0] c, logic [15:0] a);
    case (m)
      strict_greater_mode: return $signed(c) > $signed(a);
      greater_equal_mode: return $signed(c) >= $signed(a);
      strict_less_mode: return $signed(c) < $signed(a);
      default: return $signed(c) <= $signed(a);
    endcase
  endfunction

  task automatic do_reset();
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    #1;
  endtask

  // one request, then idle; outputs are looked at in the answer cycle
  task automatic go(input vpsa_req_t r, input logic [31:0] ptr);
    @(posedge clk);
    req <= r;
    array_pointer_reg <= ptr;
    @(posedge clk);
    req <= '0;
    // a stale pointer afterwards shows up if capture is late
    array_pointer_reg <= ~ptr;
    #1;
  endtask

  task automatic t_reset();
    do_reset();
    chk({result_valid, capture_valid, illegal_issue, flags}, 64'h0);
    chk(accumulator_zero, 64'h0);
    chk(accumulator_one, 64'h0);
    chk(upper_index_capture, 64'h0);
    chk(lower_index_capture, 64'h0);
    chk(result_word, 64'h0);
  endtask

  task automatic t_negate_pack();
    vpsa_req_t p;
    go(mk(VPSA_OP_NEG, strict_greater_mode, 32'h0004_7fff), 32'h0);
    chk(result_valid, 1'b1);
    chk(result_word, 32'hfffc_8001);
    chk(flags, 5'h08);
    go(mk(VPSA_OP_NEG, strict_greater_mode, 32'h8000_0000), 32'h0);
    chk(result_word, 32'h7fff_0000);
    chk(flags, 5'h17);
    p = mk(VPSA_OP_PACK, strict_greater_mode, 32'h0);
    p.pack_half_0 = 16'hdead;
    p.pack_half_1 = 16'hbeef;
    go(p, 32'h0);
    chk(result_valid, 1'b1);
    chk(result_word, 32'hdead_beef);
    chk(flags, 5'h17);
    go(mk(VPSA_OP_SEARCH, strict_less_mode, 32'h0001_0001), 32'h40);
    chk(flags, 5'h17);
  endtask

  task automatic t_search();
    logic [31:0] w [3] = '{32'h0005_fffe, 32'h0005_0007, 32'hfff0_fffe};
    logic [39:0] e0;
    logic [39:0] e1;
    logic [31:0] c0;
    logic [31:0] c1;
    logic [31:0] ptr;
    for (int m = 0; m < 4; m++) begin
      do_reset();
      e0 = '0;
      e1 = '0;
      c0 = '0;
      c1 = '0;
      for (int i = 0; i < 3; i++) begin
        ptr = 32'h100 + 32'(4 * i);
        go(mk(VPSA_OP_SEARCH, vpsa_mode_t'(m), w[i]), ptr);
        if (takes(vpsa_mode_t'(m), w[i][31:16], e1[15:0])) begin
          e1 = {{24{w[i][31]}}, w[i][31:16]};
          c1 = ptr;
        end
        if (takes(vpsa_mode_t'(m), w[i][15:0], e0[15:0])) begin
          e0 = {{24{w[i][15]}}, w[i][15:0]};
          c0 = ptr;
        end
        chk(capture_valid, 1'b1);
        chk(accumulator_one, e1);
        chk(upper_index_capture, c1);
        chk(accumulator_zero, e0);
        chk(lower_index_capture, c0);
      end
    end
  endtask

  // refused bundles first, then the permitted companions
  task automatic t_issue();
    vpsa_req_t r [7];
    logic [39:0] a1;
    for (int i = 0; i < 7; i++)
      r[i] = mk(i == 2 || i == 6 ? VPSA_OP_NEG : VPSA_OP_SEARCH, strict_greater_mode, 32'h7fff_7fff);
    r[0].mode = no_search_mode;
    r[1].op = VPSA_OP_PACK;
    r[1].wide = 1'b0;
    r[2].slot_a = VPSA_COMP_OTHER;
    r[3].slot_a = VPSA_COMP_PTR_LOAD;
    r[3].slot_reg_index = 1'b1;
    r[4].slot_a = VPSA_COMP_PTR_LOAD;
    r[4].slot_b = VPSA_COMP_PTR_LOAD;
    r[5].slot_a = VPSA_COMP_PTR_LOAD;
    r[5].slot_b = VPSA_COMP_NOP;
    r[6].slot_a = VPSA_COMP_NOP;
    r[6].slot_b = VPSA_COMP_PTR_LOAD;
    a1 = accumulator_one;
    for (int i = 0; i < 7; i++) begin
      go(r[i], 32'h200);
      chk(illegal_issue, i < 5);
      chk(capture_valid, i == 5);
      chk(result_valid, i == 6);
      if (i < 5)
        chk(accumulator_one, a1);
    end
  endtask

  initial begin
    #200000;
    n_mismatch++;
    end_of_test();
  end

  initial begin
    t_reset();
    t_negate_pack();
    t_search();
    t_issue();
    end_of_test();
  end
endmodule // vpsa_alu_bench
